// ==== design/scm_clock_ctrl.sv ====
// Contract
// - System clock chosen from precision, crystal and watchdog oscillators.
// - Reset selects the internal precision oscillator; control register may change it.
// - Selected clock passes a programmable ratio divider.
// - Flash is powered down in part of each slow clock period.
// - Unlock needs E7h then 18h written to the control register.
// - Write after unlock updates the register, then it locks again.
// - Any other control register write is ignored.
// - Only key order matters; other register accesses may come between keys.
// - Low-power option clear at reset sets flash low power and ratio 08h.
// - Primary oscillator failure with detect enable raises an exception.
// - Primary failure switches the system clock to the watchdog oscillator.
// - No failover when the watchdog oscillator is already selected.
// - Primary failure declared below about 1 kHz.
// - Watchdog oscillator failure raises an exception, no clock change.
// - After watchdog failure, primary failure detection stops.
// - Watchdog failure after 8000 system clocks without a watchdog edge.
`timescale 1ns/100ps
`default_nettype none
module scm_clock_ctrl #(
	parameter int unsigned PRI_FAIL_CYCLES = scm_pkg::PRI_FAIL_CYC,
	parameter int unsigned WDT_FAIL_CYCLES = scm_pkg::WDT_FAIL_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ipo_osc,
	input wire logic i_xtal_osc,
	input wire logic i_wdt_osc,
	input wire logic i_low_power_option_bit,
	input wire logic i_ctrl_wr_stb,
	input wire logic [7:0] i_ctrl_wr_data,
	input wire logic i_ratio_wr_stb,
	input wire logic [7:0] i_ratio_wr_data,
	output scm_pkg::scm_ctrl_t o_osc_control_reg,
	output logic [7:0] o_clock_ratio_reg,
	output logic o_unlocked,
	output scm_pkg::scm_src_t o_active_src,
	output logic o_sys_clk,
	output logic o_flash_pd,
	output logic o_pri_fail_exc,
	output logic o_wdt_fail_exc,
	output logic o_pri_failed,
	output logic o_wdt_failed
);
	import scm_pkg::*;

	localparam logic [15:0] PRI_LAST = 16'(PRI_FAIL_CYCLES - 1);
	localparam logic [15:0] WDT_LAST = 16'(WDT_FAIL_CYCLES - 1);

	scm_state_t st_r;
	scm_state_t st_nxt;
	logic [OSC_NUM-1:0] osc_sync;

	// Level of one source, gated by its enable
	function automatic logic src_level(input scm_src_t sel,
			input logic [OSC_NUM-1:0] lvl, input scm_ctrl_t c);
		logic res;
		res = 1'b0;
		case (sel)
			SCM_SRC_XTAL: res = lvl[OSC_XTAL] & c.xtl_en;
			SCM_SRC_WDT: res = lvl[OSC_WDT] & c.wdt_en;
			default: res = lvl[OSC_IPO] & c.int_en;
		endcase
		return res;
	endfunction

	// Reserved code falls back to the precision oscillator
	function automatic scm_src_t src_map(input scm_src_t sel);
		scm_src_t res;
		res = sel;
		if (sel == SCM_SRC_RSVD) begin
			res = SCM_SRC_IPO;
		end
		return res;
	endfunction

	// Oscillators are foreign to i_clk
	scm_sync u_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_async({i_wdt_osc, i_xtal_osc, i_ipo_osc}),
		.o_sync(osc_sync)
	);

	logic mux_lvl;
	logic mux_rise;
	logic tgt_lvl;
	logic cur_lvl;
	logic sys_rise;
	logic wdt_rise;
	logic ctrl_commit;
	logic pri_active;
	logic wdt_active;
	scm_src_t tgt_sel;

	always_comb begin
		st_nxt = st_r;
		st_nxt.pri_exc = 1'b0;
		st_nxt.wdt_exc = 1'b0;
		ctrl_commit = 1'b0;
		tgt_sel = SCM_SRC_IPO;
		mux_lvl = 1'b0;
		mux_rise = 1'b0;
		tgt_lvl = 1'b0;
		cur_lvl = 1'b0;
		sys_rise = 1'b0;
		wdt_rise = 1'b0;
		pri_active = 1'b0;
		wdt_active = 1'b0;

		// Strap capture in the first cycle after reset release
		if (!st_r.init_done) begin
			st_nxt.init_done = 1'b1;
			if (!i_low_power_option_bit) begin
				st_nxt.ctrl.flash_low_power_enable = 1'b1;
				st_nxt.ratio = RATIO_LOW_POWER;
			end
		end else begin
			// Guarded control register write sequence
			if (i_ctrl_wr_stb) begin
				case (st_r.lock)
					SCM_LK_LOCKED: begin
						if (i_ctrl_wr_data == UNLOCK_KEY1) begin
							st_nxt.lock = SCM_LK_KEY1;
						end
					end
					SCM_LK_KEY1: begin
						if (i_ctrl_wr_data == UNLOCK_KEY2) begin
							st_nxt.lock = SCM_LK_OPEN;
						end else if (i_ctrl_wr_data == UNLOCK_KEY1) begin
							st_nxt.lock = SCM_LK_KEY1;
						end else begin
							st_nxt.lock = SCM_LK_LOCKED;
						end
					end
					SCM_LK_OPEN: begin
						st_nxt.ctrl = scm_ctrl_t'(i_ctrl_wr_data);
						st_nxt.lock = SCM_LK_LOCKED;
						ctrl_commit = 1'b1;
					end
					default: begin
						st_nxt.lock = SCM_LK_LOCKED;
					end
				endcase
			end
			// Ratio register is a plain store
			if (i_ratio_wr_stb) begin
				st_nxt.ratio = i_ratio_wr_data;
			end
		end
		// Other registers never touch the lock state

		// Source choice, forced to watchdog on failover
		tgt_sel = st_r.failover ? SCM_SRC_WDT : src_map(st_r.ctrl.sel);
		cur_lvl = src_level(st_r.cur_sel, osc_sync, st_r.ctrl);
		tgt_lvl = src_level(tgt_sel, osc_sync, st_r.ctrl);

		// Hand over while both sources sit low; on failover only the target must be low
		if (st_r.cur_sel != tgt_sel && !tgt_lvl &&
				(!cur_lvl || st_r.failover)) begin
			st_nxt.cur_sel = tgt_sel;
		end
		mux_lvl = src_level(st_nxt.cur_sel, osc_sync, st_r.ctrl);
		mux_rise = mux_lvl & ~st_r.src_prev;
		st_nxt.src_prev = mux_lvl;

		// Divider steps on rising edges of the muxed source
		if (st_r.ratio <= 8'h01) begin
			st_nxt.sys_clk = mux_lvl;
			st_nxt.div_cnt = 8'h00;
		end else if (mux_rise) begin
			if (st_r.div_cnt >= st_r.ratio - 8'h01) begin
				st_nxt.div_cnt = 8'h00;
			end else begin
				st_nxt.div_cnt = st_r.div_cnt + 8'h01;
			end
			st_nxt.sys_clk = st_nxt.div_cnt < (st_r.ratio >> 1);
		end
		sys_rise = st_nxt.sys_clk & ~st_r.sys_clk;

		// Flash sleeps in the low phase of a slow clock
		st_nxt.flash_pd = st_r.ctrl.flash_low_power_enable & ~st_nxt.sys_clk &
			(st_nxt.cur_sel != SCM_SRC_XTAL ||
			st_r.ratio >= FAST_RATIO_MIN);

		// A committed write rearms primary detection
		if (ctrl_commit) begin
			st_nxt.pri_failed = 1'b0;
			st_nxt.failover = 1'b0;
		end

		// Primary watch: i_clk cycles since last source edge
		pri_active = st_r.ctrl.primary_fail_detect_enable & ~st_r.wdt_failed &
			~st_r.pri_failed & (st_r.cur_sel != SCM_SRC_WDT);
		if (!pri_active || mux_rise) begin
			st_nxt.pri_cnt = 16'h0000;
		end else if (st_r.pri_cnt == PRI_LAST) begin
			st_nxt.pri_cnt = 16'h0000;
			st_nxt.pri_failed = 1'b1;
			st_nxt.pri_exc = 1'b1;
			if (src_map(st_r.ctrl.sel) != SCM_SRC_WDT) begin
				st_nxt.failover = 1'b1;
			end
		end else begin
			st_nxt.pri_cnt = st_r.pri_cnt + 16'h0001;
		end

		// Watchdog watch: system clocks since last watchdog edge
		wdt_rise = osc_sync[OSC_WDT] & ~st_r.wdt_prev;
		st_nxt.wdt_prev = osc_sync[OSC_WDT];
		wdt_active = st_r.ctrl.watchdog_osc_fail_detect_enable &
			~st_r.wdt_failed;
		if (!wdt_active || wdt_rise) begin
			st_nxt.wdt_cnt = 16'h0000;
		end else if (sys_rise) begin
			if (st_r.wdt_cnt == WDT_LAST) begin
				st_nxt.wdt_failed = 1'b1;
				st_nxt.wdt_exc = 1'b1;
			end else begin
				st_nxt.wdt_cnt = st_r.wdt_cnt + 16'h0001;
			end
		end
	end

	// State register, reset picks the precision oscillator
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '0;
			st_r.lock <= SCM_LK_LOCKED;
			st_r.ctrl <= scm_ctrl_t'(CTRL_RST);
			st_r.ratio <= RATIO_RST;
			st_r.cur_sel <= SCM_SRC_IPO;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register
	assign o_osc_control_reg = st_r.ctrl;
	assign o_clock_ratio_reg = st_r.ratio;
	assign o_unlocked = st_r.lock[2]; // One-hot open bit, no decode
	assign o_active_src = st_r.cur_sel;
	assign o_sys_clk = st_r.sys_clk;
	assign o_flash_pd = st_r.flash_pd;
	assign o_pri_fail_exc = st_r.pri_exc;
	assign o_wdt_fail_exc = st_r.wdt_exc;
	assign o_pri_failed = st_r.pri_failed;
	assign o_wdt_failed = st_r.wdt_failed;

endmodule // scm_clock_ctrl
`default_nettype wire

// ==== include/scm_pkg.sv ====
`default_nettype none
package scm_pkg;

	// Reference clock and timing
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned PRI_FAIL_HZ = 1_000;
	localparam int unsigned PRI_FAIL_CYC = CLK_HZ / PRI_FAIL_HZ;
	localparam int unsigned WDT_FAIL_CYC = 8_000;
	localparam int unsigned FAST_FLASH_HZ = 10_000_000;
	localparam logic [7:0] FAST_RATIO_MIN = 8'((CLK_HZ + FAST_FLASH_HZ - 1) / FAST_FLASH_HZ);

	// Unlock keys and reset values
	localparam logic [7:0] UNLOCK_KEY1 = 8'he7;
	localparam logic [7:0] UNLOCK_KEY2 = 8'h18;
	localparam logic [7:0] CTRL_RST = 8'ha0;
	localparam logic [7:0] RATIO_RST = 8'h00;
	localparam logic [7:0] RATIO_LOW_POWER = 8'h08;

	// Oscillator level vector positions
	localparam int unsigned OSC_IPO = 0;
	localparam int unsigned OSC_XTAL = 1;
	localparam int unsigned OSC_WDT = 2;
	localparam int unsigned OSC_NUM = 3;

	typedef enum logic [1:0] {
		SCM_SRC_IPO = 2'h0,
		SCM_SRC_XTAL = 2'h1,
		SCM_SRC_WDT = 2'h2,
		SCM_SRC_RSVD = 2'h3
	} scm_src_t;

	// Field layout of osc_control_reg, bit 7 down to bit 0
	typedef struct packed {
		logic int_en;
		logic xtl_en;
		logic wdt_en;
		logic primary_fail_detect_enable;
		logic watchdog_osc_fail_detect_enable;
		logic flash_low_power_enable;
		scm_src_t sel;
	} scm_ctrl_t;

	typedef enum logic [2:0] {
		SCM_LK_LOCKED = 3'h1,
		SCM_LK_KEY1 = 3'h2,
		SCM_LK_OPEN = 3'h4
	} scm_lock_t;

	typedef struct packed {
		logic [OSC_NUM-1:0] meta;
		logic [OSC_NUM-1:0] sync;
	} scm_sync_t;

	typedef struct packed {
		scm_lock_t lock;
		scm_ctrl_t ctrl;
		logic [7:0] ratio;
		logic init_done;
		scm_src_t cur_sel;
		logic src_prev;
		logic [7:0] div_cnt;
		logic sys_clk;
		logic [15:0] pri_cnt;
		logic pri_failed;
		logic failover;
		logic wdt_prev;
		logic [15:0] wdt_cnt;
		logic wdt_failed;
		logic pri_exc;
		logic wdt_exc;
		logic flash_pd;
	} scm_state_t;

endpackage
`default_nettype wire

// ==== design/scm_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module scm_sync (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [scm_pkg::OSC_NUM-1:0] i_async,
	output logic [scm_pkg::OSC_NUM-1:0] o_sync
);
	import scm_pkg::*;

	scm_sync_t st_r;
	scm_sync_t st_nxt;

	// Two-stage capture of the oscillator levels
	always_comb begin
		st_nxt.meta = i_async;
		st_nxt.sync = st_r.meta;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_sync = st_r.sync;

endmodule // scm_sync
`default_nettype wire

// ==== dv/scm_osc_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module scm_osc_model (
	input wire logic [2:0] i_run,
	output logic [2:0] o_osc
);
	// Three free sources off the clock grid; a stopped one rests low
	initial begin
		o_osc = 3'h0;
		#13;
		fork
			forever #200 o_osc[0] = i_run[0] & ~o_osc[0];
			forever #150 o_osc[1] = i_run[1] & ~o_osc[1];
			forever #300 o_osc[2] = i_run[2] & ~o_osc[2];
		join
	end
endmodule // scm_osc_model
`default_nettype wire

// ==== dv/scm_clock_ctrl_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module scm_clock_ctrl_properties (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ctrl_wr_stb,
	input wire logic [7:0] i_ctrl_wr_data,
	input wire logic i_ratio_wr_stb,
	input wire logic [7:0] i_ratio_wr_data,
	input wire scm_pkg::scm_ctrl_t o_osc_control_reg,
	input wire logic [7:0] o_clock_ratio_reg,
	input wire logic o_unlocked,
	input wire scm_pkg::scm_src_t o_active_src,
	input wire logic o_sys_clk,
	input wire logic o_flash_pd,
	input wire logic o_pri_fail_exc,
	input wire logic o_wdt_fail_exc,
	input wire logic o_pri_failed,
	input wire logic o_wdt_failed
);
	import scm_pkg::*;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// Writes in the first cycle after reset are dropped, hence $past reset
	a_key_unlock: assert property (
		!o_unlocked && i_ctrl_wr_stb && i_ctrl_wr_data == UNLOCK_KEY1 &&
		$past(i_rst_n) ##1 i_ctrl_wr_stb && i_ctrl_wr_data == UNLOCK_KEY2
		|=> o_unlocked) else $error("unlock keys not honoured");
	a_commit_relock: assert property (o_unlocked && i_ctrl_wr_stb |=>
		!o_unlocked && o_osc_control_reg == $past(i_ctrl_wr_data))
		else $error("commit or relock wrong");
	a_locked_hold: assert property (
		!o_unlocked && $past(i_rst_n) |=> $stable(o_osc_control_reg))
		else $error("locked register changed");
	a_ratio_load: assert property (
		i_ratio_wr_stb && $past(i_rst_n) |=>
		o_clock_ratio_reg == $past(i_ratio_wr_data))
		else $error("ratio write lost");
	a_pri_exc_pulse: assert property (o_pri_fail_exc |=>
		!o_pri_fail_exc && o_pri_failed) else $error("primary pulse bad");
	a_wdt_exc_pulse: assert property (o_wdt_fail_exc |=>
		!o_wdt_fail_exc && o_wdt_failed) else $error("watchdog pulse bad");
	a_wdt_blocks_pri: assert property (
		o_wdt_failed && !o_pri_failed |=> !o_pri_fail_exc)
		else $error("primary fault after watchdog fault");
	a_flash_gate: assert property (o_flash_pd |->
		(o_osc_control_reg.flash_low_power_enable ||
		$past(o_osc_control_reg.flash_low_power_enable)) &&
		!(o_sys_clk && $past(o_sys_clk))) else $error("flash down wrongly");
	a_failover_src: assert property (
		$rose(o_pri_failed) && o_osc_control_reg.sel != SCM_SRC_WDT |->
		##[1:40] o_active_src == SCM_SRC_WDT) else $error("no failover");
endmodule // scm_clock_ctrl_properties
`default_nettype wire

// ==== dv/scm_clock_ctrl_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module scm_clock_ctrl_tb;
	import scm_pkg::*;
	localparam int PRI_C = 50;
	localparam int WDT_C = 10;
	logic i_clk, i_rst_n, lp_opt, c_stb, r_stb;
	logic [7:0] c_dat, r_dat, mctrl, mratio, ctrl, ratio;
	logic [2:0] run, osc;
	logic unl, sys_clk, fpd, pexc, wexc, pfail, wfail;
	logic [31:0] r;
	scm_src_t src;
	int err_count, comparisons, cyc, lk, rises, seed, i, k, r0;
	int dv[4] = '{0, 1, 2, 5};
	time t0;
	scm_osc_model osc_m (.i_run(run), .o_osc(osc));
	scm_clock_ctrl #(.PRI_FAIL_CYCLES(PRI_C), .WDT_FAIL_CYCLES(WDT_C)) dut (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ipo_osc(osc[0]),
		.i_xtal_osc(osc[1]), .i_wdt_osc(osc[2]),
		.i_low_power_option_bit(lp_opt), .i_ctrl_wr_stb(c_stb),
		.i_ctrl_wr_data(c_dat), .i_ratio_wr_stb(r_stb),
		.i_ratio_wr_data(r_dat), .o_osc_control_reg(ctrl),
		.o_clock_ratio_reg(ratio), .o_unlocked(unl), .o_active_src(src),
		.o_sys_clk(sys_clk), .o_flash_pd(fpd), .o_pri_fail_exc(pexc),
		.o_wdt_fail_exc(wexc), .o_pri_failed(pfail), .o_wdt_failed(wfail));
	// Clock, hang guard and divided clock edge count
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			summarize();
		end
	end
	always @(posedge sys_clk) rises++;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask
	task automatic summarize();
		$display("comparisons=%0d err_count=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Reset, then compare the strap-dependent reset values
	task automatic do_rst(input logic opt);
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		lp_opt <= opt;
		run <= 3'h7;
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (2) @(posedge i_clk);
		#1;
		lk = 0;
		mctrl = opt ? CTRL_RST : CTRL_RST | 8'h04;
		mratio = opt ? RATIO_RST : RATIO_LOW_POWER;
		chk(ctrl, mctrl);
		chk(ratio, mratio);
		chk({6'h0, src}, {6'h0, SCM_SRC_IPO});
	endtask
	// Control write with the lock model: 0 locked, 1 first key, 2 open
	task automatic wr_ctrl(input logic [7:0] d);
		@(posedge i_clk);
		c_stb <= 1'b1;
		c_dat <= d;
		@(posedge i_clk);
		c_stb <= 1'b0;
		#1;
		if (lk == 2) begin
			mctrl = d;
			lk = 0;
		end else if (lk == 1 && d == UNLOCK_KEY2) lk = 2;
		else lk = (d == UNLOCK_KEY1) ? 1 : 0;
		chk({7'h0, unl}, 8'(lk == 2));
		chk(ctrl, mctrl);
	endtask
	task automatic wr3(input logic [7:0] d);
		wr_ctrl(UNLOCK_KEY1);
		wr_ctrl(UNLOCK_KEY2);
		wr_ctrl(d);
	endtask
	task automatic wr_ratio(input logic [7:0] d);
		@(posedge i_clk);
		r_stb <= 1'b1;
		r_dat <= d;
		@(posedge i_clk);
		r_stb <= 1'b0;
		#1;
		mratio = d;
		chk(ratio, mratio);
	endtask
	task automatic wait_src(input scm_src_t s);
		for (k = 0; k < 200 && src !== s; k++) @(posedge i_clk);
		#1;
		chk({6'h0, src}, {6'h0, s});
	endtask
	// Main sequence
	initial begin
		i_rst_n = 1'b0;
		lp_opt = 1'b1;
		{c_stb, r_stb, c_dat, r_dat} = 18'h0;
		run = 3'h7;
		seed = 41381;
		do_rst(1'b1);
		for (i = 0; i < 60; i++) begin
			r = $random(seed);
			if (r[2]) wr_ratio(r[23:16]);
			wr_ctrl(r[0] ? (lk == 1 ? UNLOCK_KEY2 : UNLOCK_KEY1) : r[15:8]);
		end
		do_rst(1'b0);
		foreach (dv[i]) begin
			wr_ratio(8'(dv[i]));
			repeat (2) @(posedge sys_clk);
			t0 = $time;
			@(posedge sys_clk);
			chk(8'(($time - t0) / 50), 8'(8 * (dv[i] < 2 ? 1 : dv[i])));
		end
		@(negedge sys_clk);
		@(posedge i_clk);
		#1;
		chk({7'h0, fpd}, 8'h1);
		wr3(8'hf1);
		wait_src(SCM_SRC_XTAL);
		run <= 3'h5;
		for (k = 0; k < PRI_C + 40 && pexc !== 1'b1; k++) begin
			@(posedge i_clk);
			#1;
		end
		chk({7'h0, pexc}, 8'h1);
		wait_src(SCM_SRC_WDT);
		do_rst(1'b1);
		wr3(8'hf2);
		wait_src(SCM_SRC_WDT);
		run <= 3'h3;
		repeat (PRI_C + 20) @(posedge i_clk);
		chk({5'h0, pfail, src}, {5'h0, 1'b0, SCM_SRC_WDT});
		do_rst(1'b1);
		wr3(8'hb8);
		r0 = rises;
		run <= 3'h3;
		for (k = 0; k < 3000 && wfail !== 1'b1; k++) begin
			@(posedge i_clk);
			#1;
		end
		chk({7'h0, wexc}, 8'h1);
		chk({7'h0, rises - r0 >= WDT_C - 2 && rises - r0 <= WDT_C + 2}, 8'h1);
		chk({6'h0, src}, {6'h0, SCM_SRC_IPO});
		run <= 3'h2;
		repeat (PRI_C + 40) @(posedge i_clk);
		chk({7'h0, pfail}, 8'h0);
		summarize();
	end
endmodule // scm_clock_ctrl_tb
bind scm_clock_ctrl scm_clock_ctrl_properties u_props (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ctrl_wr_stb(i_ctrl_wr_stb),
	.i_ctrl_wr_data(i_ctrl_wr_data), .i_ratio_wr_stb(i_ratio_wr_stb),
	.i_ratio_wr_data(i_ratio_wr_data), .o_osc_control_reg(o_osc_control_reg),
	.o_clock_ratio_reg(o_clock_ratio_reg), .o_unlocked(o_unlocked),
	.o_active_src(o_active_src), .o_sys_clk(o_sys_clk),
	.o_flash_pd(o_flash_pd), .o_pri_fail_exc(o_pri_fail_exc),
	.o_wdt_fail_exc(o_wdt_fail_exc), .o_pri_failed(o_pri_failed),
	.o_wdt_failed(o_wdt_failed));
`default_nettype wire
